// ===== inc/aed_consts.svh
`ifndef AED_CONSTS_SVH
`define AED_CONSTS_SVH

// ---------------------------------------------------------------
// register offsets (word addresses on the plain register port)
// ---------------------------------------------------------------
`define AED_ADDR_RMS_OFS 5'h00
`define AED_ADDR_PHASE 5'h01
`define AED_ADDR_GAIN 5'h02
`define AED_ADDR_DIVIDER 5'h03
`define AED_ADDR_MODE 5'h04
`define AED_ADDR_IRQ_EN 5'h05
`define AED_ADDR_ENERGY 5'h06
`define AED_ADDR_ENERGY_RC 5'h07
`define AED_ADDR_RMS_RESULT 5'h08
`define AED_ADDR_WAVEFORM 5'h09
`define AED_ADDR_STATUS 5'h0a
`define AED_ADDR_STATUS_RC 5'h0b

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define AED_MODE_POSITIVE_ONLY_ACCUMULATE_BIT 4
`define AED_MODE_RATE_LO 11
`define AED_MODE_RATE_HI 12
`define AED_MODE_SRC_LO 13
`define AED_MODE_SRC_HI 14
`define AED_ST_HALF_BIT 0
`define AED_ST_OVF_BIT 1
`define AED_ST_UNF_BIT 2
`define AED_ST_WAVE_BIT 3
`define AED_IE_WAVEFORM_SAMPLING_ENABLE_BIT 3

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define AED_RST_PHASE 6'h0d
`define AED_RST_MODE 16'h0000
`define AED_RST_IRQ_EN 4'h0

// ---------------------------------------------------------------
// timing and scaling
// ---------------------------------------------------------------
`define AED_PHASE_CENTER 7'd13
`define AED_CUR_DELAY 7'd44
`define AED_ACC_TICK_MASK 3'b011
`define AED_PHASE_TICK 3'd7
`define AED_GAIN_SHIFT 12
`define AED_WAVE_BASE_DIV 11'd128

`endif

// ===== inc/aed_pkg.sv
package aed_pkg;

    // one pair of adc samples, current and voltage channel
    typedef struct packed {
        logic signed [15:0] current;
        logic signed [15:0] voltage;
    } aed_sample_type;

    // register port request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [4:0] addr;
        logic [23:0] wdata;
    } aed_bus_req_type;

    // one-cycle energy event pulses
    typedef struct packed {
        logic half_full;
        logic overflow;
        logic underflow;
    } aed_event_type;

endpackage

// ===== rtl/aed_phase_delay.sv
`timescale 1ns/1ps
module aed_phase_delay #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 64,
    parameter int AW = 6
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic shift_en,
    input wire logic [WIDTH-1:0] din,
    input wire logic [AW-1:0] tap,
    output logic [WIDTH-1:0] dout
);
    import aed_pkg::*;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wptr_r;

    // ---------------------------------------------------------------
    // sample history
    // ---------------------------------------------------------------
    // cleared at reset so an early read never shows junk
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= '0;
            end
            wptr_r <= '0;
        end else if (shift_en) begin
            mem[wptr_r] <= din;
            wptr_r <= wptr_r + 1'b1;
        end
    end

    // tap 0 is the newest stored sample
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            dout <= '0;
        end else begin
            dout <= mem[AW'(wptr_r - 1'b1 - tap)];
        end
    end
endmodule

// ===== rtl/aed_datapath.sv
`timescale 1ns/1ps
`include "aed_consts.svh"
module aed_datapath #(
    parameter int LPF_SHIFT = 8
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire aed_pkg::aed_sample_type adc_samples,
    input wire logic [23:0] voltage_rms_raw,
    input wire aed_pkg::aed_bus_req_type bus_req,
    output logic [23:0] rd_data,
    output logic [23:0] voltage_rms_result,
    output aed_pkg::aed_event_type energy_events,
    output logic irq_n
);
    import aed_pkg::*;

    // ---------------------------------------------------------------
    // declarations
    // ---------------------------------------------------------------
    logic [11:0] voltage_rms_offset_r;
    logic [5:0] phase_delay_trim_r;
    logic [11:0] power_gain_trim_r;
    logic [7:0] energy_divider_r;
    logic [15:0] mode_r;
    logic [3:0] irq_en_r;
    logic [3:0] status_r;
    logic [23:0] waveform_r;
    logic [2:0] tick_cnt_r;
    logic tick4;
    logic tick8;
    logic [6:0] volt_tap;
    logic [15:0] cur_dly;
    logic [15:0] volt_dly;
    logic signed [31:0] product;
    logic signed [31:0] lpf_r;
    logic signed [32:0] lpf_diff;
    logic signed [32:0] lpf_step;
    logic signed [43:0] gain_prod;
    logic signed [33:0] power_r;
    logic signed [33:0] quotient_r;
    logic signed [48:0] acc_r;
    logic signed [48:0] acc_add;
    logic signed [48:0] acc_nxt;
    logic do_add;
    logic rd_clear;
    logic rd_stat_clear;
    aed_event_type ev_nxt;
    logic positive_only_accumulate;
    logic [1:0] waveform_rate_select;
    logic [1:0] waveform_source;
    logic waveform_sampling_enable;
    logic wave_run;
    logic [10:0] wave_cnt_r;
    logic [10:0] wave_period;
    logic wave_fire;

    // divider value zero is taken as one
    function automatic logic signed [33:0] div_power(input logic signed [33:0] p,
                                                       input logic [7:0] d);
        logic signed [33:0] dd;
        dd = {26'h0, d};
        if (d == 8'h00) begin
            div_power = p;
        end else begin
            div_power = p / dd;
        end
    endfunction

    assign positive_only_accumulate = mode_r[`AED_MODE_POSITIVE_ONLY_ACCUMULATE_BIT];
    assign waveform_rate_select = mode_r[`AED_MODE_RATE_HI:`AED_MODE_RATE_LO];
    assign waveform_source = mode_r[`AED_MODE_SRC_HI:`AED_MODE_SRC_LO];
    assign waveform_sampling_enable = irq_en_r[`AED_IE_WAVEFORM_SAMPLING_ENABLE_BIT];
    assign rd_clear = bus_req.rd && (bus_req.addr == `AED_ADDR_ENERGY_RC);
    assign rd_stat_clear = bus_req.rd && (bus_req.addr == `AED_ADDR_STATUS_RC);

    // ---------------------------------------------------------------
    // register writes
    // ---------------------------------------------------------------
    // offset, phase, gain, divider, mode and irq enable storage
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            voltage_rms_offset_r <= 12'h000;
            phase_delay_trim_r <= `AED_RST_PHASE;
            power_gain_trim_r <= 12'h000;
            energy_divider_r <= 8'h00;
            mode_r <= `AED_RST_MODE;
            irq_en_r <= `AED_RST_IRQ_EN;
        end else if (bus_req.wr) begin
            if (bus_req.addr == `AED_ADDR_RMS_OFS) begin
                voltage_rms_offset_r <= bus_req.wdata[11:0];
            end else if (bus_req.addr == `AED_ADDR_PHASE) begin
                phase_delay_trim_r <= bus_req.wdata[5:0];
            end else if (bus_req.addr == `AED_ADDR_GAIN) begin
                power_gain_trim_r <= bus_req.wdata[11:0];
            end else if (bus_req.addr == `AED_ADDR_DIVIDER) begin
                energy_divider_r <= bus_req.wdata[7:0];
            end else if (bus_req.addr == `AED_ADDR_MODE) begin
                mode_r <= bus_req.wdata[15:0];
            end else if (bus_req.addr == `AED_ADDR_IRQ_EN) begin
                irq_en_r <= bus_req.wdata[3:0];
            end
        end
    end

    // ---------------------------------------------------------------
    // register reads
    // ---------------------------------------------------------------
    // data valid only the cycle after the strobe, zero otherwise
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_data <= 24'h000000;
        end else if (!bus_req.rd) begin
            rd_data <= 24'h000000;
        end else if (bus_req.addr == `AED_ADDR_RMS_OFS) begin
            rd_data <= {12'h000, voltage_rms_offset_r};
        end else if (bus_req.addr == `AED_ADDR_PHASE) begin
            rd_data <= {18'h0, phase_delay_trim_r};
        end else if (bus_req.addr == `AED_ADDR_GAIN) begin
            rd_data <= {12'h000, power_gain_trim_r};
        end else if (bus_req.addr == `AED_ADDR_DIVIDER) begin
            rd_data <= {16'h0000, energy_divider_r};
        end else if (bus_req.addr == `AED_ADDR_MODE) begin
            rd_data <= {8'h00, mode_r};
        end else if (bus_req.addr == `AED_ADDR_IRQ_EN) begin
            rd_data <= {20'h0, irq_en_r};
        end else if (bus_req.addr == `AED_ADDR_ENERGY || rd_clear) begin
            rd_data <= acc_r[48:25];
        end else if (bus_req.addr == `AED_ADDR_RMS_RESULT) begin
            rd_data <= voltage_rms_result;
        end else if (bus_req.addr == `AED_ADDR_WAVEFORM) begin
            rd_data <= waveform_r;
        end else if (bus_req.addr == `AED_ADDR_STATUS || rd_stat_clear) begin
            rd_data <= {20'h0, status_r};
        end else begin
            rd_data <= 24'h000000;
        end
    end

    // ---------------------------------------------------------------
    // rms offset correction
    // ---------------------------------------------------------------
    // add signed offset
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            voltage_rms_result <= 24'h000000;
        end else begin
            voltage_rms_result <= voltage_rms_raw + {{12{voltage_rms_offset_r[11]}},
                                                     voltage_rms_offset_r};
        end
    end

    // ---------------------------------------------------------------
    // sample ticks
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tick_cnt_r <= 3'd0;
        end else begin
            tick_cnt_r <= tick_cnt_r + 3'd1;
        end
    end
    assign tick8 = (tick_cnt_r == `AED_PHASE_TICK);
    assign tick4 = ((tick_cnt_r & `AED_ACC_TICK_MASK) == `AED_ACC_TICK_MASK);

    // ---------------------------------------------------------------
    // phase trim
    // ---------------------------------------------------------------
    // centered voltage tap
    // current sits at a fixed lag so the voltage path can also lead it
    assign volt_tap = `AED_CUR_DELAY + {phase_delay_trim_r[5], phase_delay_trim_r}
                      - `AED_PHASE_CENTER;

    aed_phase_delay #(.WIDTH(16), .DEPTH(64), .AW(6)) u_cur_delay (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .shift_en(tick8),
        .din(adc_samples.current),
        .tap(6'(`AED_CUR_DELAY)),
        .dout(cur_dly)
    );

    aed_phase_delay #(.WIDTH(16), .DEPTH(64), .AW(6)) u_volt_delay (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .shift_en(tick8),
        .din(adc_samples.voltage),
        .tap(volt_tap[5:0]),
        .dout(volt_dly)
    );

    // ---------------------------------------------------------------
    // active power
    // ---------------------------------------------------------------
    // multiply and low-pass
    assign product = $signed(cur_dly) * $signed(volt_dly);
    assign lpf_diff = {product[31], product} - {lpf_r[31], lpf_r};
    assign lpf_step = lpf_diff >>> LPF_SHIFT;

    // first-order filter; ripple at twice line remains, the sum removes it
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            lpf_r <= 32'sh0;
        end else if (tick8) begin
            lpf_r <= lpf_r + lpf_step[31:0];
        end
    end

    assign gain_prod = lpf_r * $signed(power_gain_trim_r);
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            power_r <= 34'sh0;
        end else begin
            power_r <= {{2{lpf_r[31]}}, lpf_r} + {{2{gain_prod[43]}}, gain_prod[43:`AED_GAIN_SHIFT]};
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            quotient_r <= 34'sh0;
        end else begin
            quotient_r <= div_power(power_r, energy_divider_r);
        end
    end

    // ---------------------------------------------------------------
    // energy accumulator
    // ---------------------------------------------------------------
    // signed or positive-only
    assign acc_add = {{15{quotient_r[33]}}, quotient_r};
    assign do_add = tick4 && !(positive_only_accumulate && quotient_r[33]);

    always_comb begin
        acc_nxt = acc_r;
        if (do_add) begin
            acc_nxt = acc_r + acc_add;
        end
        if (rd_clear) begin
            acc_nxt[48:25] = 24'h000000;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            acc_r <= 49'sh0;
        end else begin
            acc_r <= acc_nxt;
        end
    end

    always_comb begin
        ev_nxt = '0;
        if (do_add) begin
            ev_nxt.overflow = !acc_add[48] && !acc_r[48] && acc_nxt[48];
            ev_nxt.underflow = acc_add[48] && acc_r[48] && !acc_nxt[48];
            ev_nxt.half_full = !(acc_r[48] ^ acc_r[47]) && (acc_nxt[48] ^ acc_nxt[47]);
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            energy_events <= '0;
        end else begin
            energy_events <= ev_nxt;
        end
    end

    // ---------------------------------------------------------------
    // waveform sampling
    // ---------------------------------------------------------------
    // rate and gating
    assign wave_run = (waveform_source == 2'b00) && waveform_sampling_enable;
    assign wave_period = (`AED_WAVE_BASE_DIV << waveform_rate_select) - 11'd1;
    assign wave_fire = wave_run && (wave_cnt_r >= wave_period);

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wave_cnt_r <= 11'd0;
        end else if (!wave_run || wave_fire) begin
            wave_cnt_r <= 11'd0;
        end else begin
            wave_cnt_r <= wave_cnt_r + 11'd1;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            waveform_r <= 24'h000000;
        end else if (wave_fire) begin
            waveform_r <= power_r[31:8];
        end
    end

    // ---------------------------------------------------------------
    // status and interrupt line
    // ---------------------------------------------------------------
    // sticky, set beats clear
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            status_r <= 4'h0;
        end else begin
            status_r <= (rd_stat_clear ? 4'h0 : status_r)
                        | {wave_fire, energy_events.underflow,
                           energy_events.overflow, energy_events.half_full};
        end
    end

    assign irq_n = ~|(status_r & irq_en_r);

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    sequence s_clear_read;
        rd_clear && !do_add;
    endsequence

    property p_rms_sum;
        @(posedge sys_clk) disable iff (sys_rst)
        1'b1 |=> voltage_rms_result == $past(voltage_rms_raw)
                 + {{12{$past(voltage_rms_offset_r[11])}}, $past(voltage_rms_offset_r)};
    endproperty
    a_rms_sum: assert property (p_rms_sum) else $error("rms offset sum wrong");

    property p_phase_center;
        @(posedge sys_clk) disable iff (sys_rst)
        phase_delay_trim_r == 6'h0d |-> volt_tap == `AED_CUR_DELAY;
    endproperty
    a_phase_center: assert property (p_phase_center) else $error("center tap off");

    property p_tick_spacing;
        @(posedge sys_clk) disable iff (sys_rst)
        tick4 |=> !tick4 [*3] ##1 tick4;
    endproperty
    a_tick_spacing: assert property (p_tick_spacing) else $error("add tick spacing");

    property p_hold_between;
        @(posedge sys_clk) disable iff (sys_rst)
        !tick4 && !rd_clear |=> acc_r == $past(acc_r);
    endproperty
    a_hold_between: assert property (p_hold_between) else $error("acc moved off tick");

    property p_positive_only_accumulate_skip;
        @(posedge sys_clk) disable iff (sys_rst)
        positive_only_accumulate && quotient_r[33] && !rd_clear |=> acc_r == $past(acc_r);
    endproperty
    a_positive_only_accumulate_skip: assert property (p_positive_only_accumulate_skip) else $error("negative added in positive_only_accumulate");

    property p_div_zero;
        @(posedge sys_clk) disable iff (sys_rst)
        energy_divider_r == 8'h00 && $stable(energy_divider_r) |=> quotient_r == $past(power_r);
    endproperty
    a_div_zero: assert property (p_div_zero) else $error("divide by zero not one");

    property p_clear_read;
        @(posedge sys_clk) disable iff (sys_rst)
        s_clear_read |=> rd_data == $past(acc_r[48:25]) && acc_r[48:25] == 24'h000000;
    endproperty
    a_clear_read: assert property (p_clear_read) else $error("clearing read wrong");

    property p_plain_read;
        @(posedge sys_clk) disable iff (sys_rst)
        bus_req.rd && bus_req.addr == `AED_ADDR_ENERGY && !tick4 |=> acc_r == $past(acc_r);
    endproperty
    a_plain_read: assert property (p_plain_read) else $error("plain read disturbed acc");

    property p_wave_gate;
        @(posedge sys_clk) disable iff (sys_rst)
        !wave_run |=> $stable(waveform_r);
    endproperty
    a_wave_gate: assert property (p_wave_gate) else $error("waveform updated while off");

    property p_event_sticky;
        @(posedge sys_clk) disable iff (sys_rst)
        energy_events.overflow |=> status_r[`AED_ST_OVF_BIT]
            ##1 (status_r[`AED_ST_OVF_BIT] || $past(rd_stat_clear));
    endproperty
    a_event_sticky: assert property (p_event_sticky) else $error("overflow not held");

    property p_irq_level;
        @(posedge sys_clk) disable iff (sys_rst)
        (|(status_r & irq_en_r)) && !rd_stat_clear
            && !(bus_req.wr && bus_req.addr == `AED_ADDR_IRQ_EN) |=> !irq_n;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq released early");
endmodule

// ===== tb/aed_mcu_model.sv
`timescale 1ns/1ps
module aed_mcu_model (
    input wire logic sys_clk,
    output aed_pkg::aed_bus_req_type bus_req,
    input wire logic [23:0] rd_data
);
    import aed_pkg::*;

    // --------------------------------
    // register port master
    // --------------------------------
    // bus idle from time zero
    initial begin
        bus_req = '0;
    end

    // one-cycle write strobe
    task automatic reg_wr(input logic [4:0] a, input logic [23:0] d);
        @(posedge sys_clk);
        bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge sys_clk);
        bus_req <= '0;
    endtask

    // read data is valid only in the cycle after the strobe, so sample it there
    task automatic reg_rd(input logic [4:0] a, output logic [23:0] d);
        @(posedge sys_clk);
        bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 24'h000000};
        @(posedge sys_clk);
        bus_req <= '0;
        #1;
        d = rd_data;
    endtask
endmodule

// ===== tb/aed_datapath_test.sv
`timescale 1ns/1ps
`include "aed_consts.svh"
module aed_datapath_test;
    import aed_pkg::*;

    logic sys_clk;
    logic sys_rst;
    aed_sample_type samp;
    logic [23:0] rms_raw;
    aed_bus_req_type bus_req;
    logic [23:0] rd_data;
    logic [23:0] rms_res;
    aed_event_type events;
    logic irq_n;
    int n_mismatch = 0;
    int comparisons = 0;

    // --------------------------------
    // design and partner
    // --------------------------------
    // short filter keeps settling time small
    aed_datapath #(.LPF_SHIFT(2)) aed_datapath_inst (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .adc_samples(samp),
        .voltage_rms_raw(rms_raw), .bus_req(bus_req), .rd_data(rd_data),
        .voltage_rms_result(rms_res), .energy_events(events), .irq_n(irq_n)
    );
    aed_mcu_model aed_mcu_model_inst (
        .sys_clk(sys_clk), .bus_req(bus_req), .rd_data(rd_data)
    );

    // --------------------------------
    // helpers
    // --------------------------------
    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic set_samp(input logic [15:0] i, input logic [15:0] v, input int wait_n);
        @(posedge sys_clk);
        samp <= '{current: i, voltage: v};
        repeat (wait_n) @(posedge sys_clk);
    endtask

    // --------------------------------
    // scenarios
    // --------------------------------
    // reset values, field widths, read-only energy
    task automatic t_regs();
        logic [23:0] d;
        aed_mcu_model_inst.reg_rd(`AED_ADDR_PHASE, d);
        check(d, 24'h00000d);
        aed_mcu_model_inst.reg_wr(`AED_ADDR_ENERGY, 24'h123456);
        aed_mcu_model_inst.reg_rd(`AED_ADDR_ENERGY, d);
        check(d, 24'h000000);
        aed_mcu_model_inst.reg_wr(`AED_ADDR_PHASE, 24'hffffe1);
        aed_mcu_model_inst.reg_rd(`AED_ADDR_PHASE, d);
        check(d, 24'h000021);
        aed_mcu_model_inst.reg_wr(`AED_ADDR_PHASE, 24'h00000d);
        aed_mcu_model_inst.reg_wr(`AED_ADDR_DIVIDER, 24'h1234ff);
        aed_mcu_model_inst.reg_rd(`AED_ADDR_DIVIDER, d);
        check(d, 24'h0000ff);
        aed_mcu_model_inst.reg_wr(`AED_ADDR_DIVIDER, 24'h000000);
        aed_mcu_model_inst.reg_rd(5'h1f, d);
        check(d, 24'h000000);
    endtask

    // signed offset added to raw rms, negative and positive extremes
    task automatic t_rms();
        logic [23:0] d;
        logic [23:0] raw [2] = '{24'h001000, 24'h000100};
        logic [23:0] ofs [2] = '{24'hfff800, 24'h0007ff};
        logic [23:0] exp [2] = '{24'h000800, 24'h0008ff};
        // offset tried at two nonzero raw levels
        for (int k = 0; k < 2; k++) begin
            @(posedge sys_clk);
            rms_raw <= raw[k];
            aed_mcu_model_inst.reg_wr(`AED_ADDR_RMS_OFS, ofs[k]);
            aed_mcu_model_inst.reg_rd(`AED_ADDR_RMS_OFS, d);
            check(d, {12'h000, ofs[k][11:0]});
            aed_mcu_model_inst.reg_rd(`AED_ADDR_RMS_RESULT, d);
            check(d, exp[k]);
            check(rms_res, exp[k]);
        end
    endtask

    // power waveform, interrupt hold and gain extremes
    task automatic t_wave_gain();
        logic [23:0] w0;
        logic [23:0] w;
        int i;
        // delay lines need about 360 clocks, the filter about 320 more
        set_samp(16'h4000, 16'h4000, 700);
        aed_mcu_model_inst.reg_wr(`AED_ADDR_IRQ_EN, 24'h000008);
        for (i = 0; i < 400 && irq_n !== 1'b0; i++) @(posedge sys_clk);
        check(irq_n, 1'b0);
        aed_mcu_model_inst.reg_rd(`AED_ADDR_WAVEFORM, w0);
        repeat (3) @(posedge sys_clk);
        check(irq_n, 1'b0);
        aed_mcu_model_inst.reg_rd(`AED_ADDR_STATUS_RC, w);
        check(irq_n, 1'b1);
        aed_mcu_model_inst.reg_wr(`AED_ADDR_GAIN, 24'h000800);
        repeat (300) @(posedge sys_clk);
        aed_mcu_model_inst.reg_rd(`AED_ADDR_WAVEFORM, w);
        // halved output, allowing filter and truncation slack
        check(($signed(w0) - 2 * $signed(w)) inside {[-16:16]}, 1'b1);
        aed_mcu_model_inst.reg_wr(`AED_ADDR_GAIN, 24'h0007ff);
        repeat (300) @(posedge sys_clk);
        aed_mcu_model_inst.reg_rd(`AED_ADDR_WAVEFORM, w);
        check((longint'($signed(w)) * 4096 - longint'($signed(w0)) * 6143)
              inside {[-16384:16384]}, 1'b1);
        aed_mcu_model_inst.reg_wr(`AED_ADDR_IRQ_EN, 24'h000000);
        aed_mcu_model_inst.reg_wr(`AED_ADDR_GAIN, 24'h000000);
    endtask

    // positive-only mode, signed decrease, clearing read
    task automatic t_energy();
        logic [23:0] e0;
        logic [23:0] d;
        aed_mcu_model_inst.reg_wr(`AED_ADDR_MODE, 24'h000010);
        set_samp(16'hc000, 16'h4000, 700);
        aed_mcu_model_inst.reg_rd(`AED_ADDR_ENERGY, e0);
        repeat (400) @(posedge sys_clk);
        aed_mcu_model_inst.reg_rd(`AED_ADDR_ENERGY, d);
        check(d, e0);
        aed_mcu_model_inst.reg_wr(`AED_ADDR_MODE, 24'h000000);
        repeat (400) @(posedge sys_clk);
        aed_mcu_model_inst.reg_rd(`AED_ADDR_ENERGY, d);
        check($signed(d) < $signed(e0), 1'b1);
        // stop all further adds before the clearing read
        aed_mcu_model_inst.reg_wr(`AED_ADDR_MODE, 24'h000010);
        set_samp(16'h0000, 16'h0000, 300);
        aed_mcu_model_inst.reg_rd(`AED_ADDR_ENERGY, e0);
        aed_mcu_model_inst.reg_rd(`AED_ADDR_ENERGY, d);
        check(d, e0);
        aed_mcu_model_inst.reg_rd(`AED_ADDR_ENERGY_RC, d);
        check(d, e0);
        aed_mcu_model_inst.reg_rd(`AED_ADDR_ENERGY, d);
        check(d, 24'h000000);
        check(events, 3'b000);
    endtask

    // --------------------------------
    // clock, reset, sequence, watchdog
    // --------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    initial begin
        sys_rst = 1'b1;
        samp = '0;
        rms_raw = 24'h000100;
        repeat (8) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_regs();
        t_rms();
        t_wave_gain();
        t_energy();
        conclude();
    end

    // whole run needs about 3300 cycles
    initial begin
        #200000;
        n_mismatch++;
        conclude();
    end
endmodule
